/* File: hw/tws_pkg.sv */
// package of the three-wire serial unit: register map, field layout,
// reset values, carrier structs and state encodings.
// assumes an APB slave with 32-bit data and word-aligned registers.
package tws_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address = index * 4)
   // ----------------------------------------------------------------
   localparam logic [15:0] IDX_MODE_CTL = 16'hFF80; // serial_mode_control
   localparam logic [15:0] IDX_CLK_SEL = 16'hFF81; // clock_select_register
   localparam logic [15:0] IDX_TX_BUF = 16'hFF82; // transmit_buffer
   localparam logic [15:0] IDX_SHIFT = 16'hFF83; // serial_shift_register
   localparam logic [15:0] IDX_IRQ_STAT = 16'hFF84; // sticky events, ro
   localparam logic [15:0] IDX_IRQ_CLR = 16'hFF85; // write 1 to clear, wo
   localparam logic [15:0] IDX_IRQ_EN = 16'hFF86; // event enables
   localparam int ADDR_W = 18; // paddr width
   localparam int IDX_LSB = 2; // word index starts here

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int POS_ENABLE = 7; // unit_enable
   localparam int POS_TMODE = 6; // transfer_mode
   localparam int POS_ORDER = 4; // first_bit_order
   localparam int POS_ACTIVE = 0; // transfer_active_flag
   localparam int POS_CKP = 4; // clock_polarity
   localparam int POS_DAP = 3; // data_phase
   localparam int POS_SRC_HI = 2; // clock_source_select msb
   localparam int POS_SRC_LO = 0; // clock_source_select lsb
   localparam int EV_DONE = 0; // transfer finished
   localparam int EV_CLASH = 1; // buffer or shifter access while active
   localparam int N_EV = 2; // number of events

   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00; // all byte registers
   localparam logic [N_EV-1:0] RST_EV = 2'h0; // status and enables
   localparam logic [2:0] SRC_EXT = 3'h7; // source: clock from pin
   localparam logic [7:0] HALF_BASE = 8'h02; // half period at source 0
   localparam logic [2:0] BIT_LAST = 3'h7; // index of eighth bit

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic enable; // unit_enable
      logic tmode; // transfer_mode: 1 = transmit/receive
      logic lsb_first; // first_bit_order
   } tws_ctl_t;

   typedef struct packed {
      logic ckp; // clock_polarity
      logic dap; // data_phase
      logic [2:0] src; // clock_source_select
   } tws_csel_t;

   typedef enum logic {TWS_IDLE, TWS_RUN} tws_state_t;

   typedef enum logic [2:0] {
      TWS_R_NONE, TWS_R_CTL, TWS_R_CSEL, TWS_R_TXB, TWS_R_SHIFT,
      TWS_R_STAT, TWS_R_CLR, TWS_R_EN
   } tws_rsel_t;

endpackage

/* File: hw/tws_sync.sv */
// two-stage synchroniser for pin inputs of the serial unit.
// assumes inputs are asynchronous to clk; q is the second stage.
`timescale 1ns/10ps
module tws_sync #(
   parameter int W = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // ----------------------------------------------------------------
   // per-bit flop pair
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta; // first stage, read only by q
         // capture then re-time each pin bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta <= 1'b0;
               q[i] <= 1'b0;
            end else if (ce) begin
               meta <= d[i];
               q[i] <= meta;
            end
         end
      end
   endgenerate
endmodule

/* File: hw/tws_serial_io.sv */
// three-wire serial shift unit with an APB register slave.
// assumes pclk at 20 MHz, pins sck_in and si asynchronous to pclk.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
module tws_serial_io
   import tws_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic si,
   output logic so,
   output logic so_oe,
   output logic irq
);
   // ----------------------------------------------------------------
   // helpers for bit order
   // ----------------------------------------------------------------
   // bit presented first on the output line
   function automatic logic out_bit(input logic [7:0] v, input logic lsb);
      out_bit = lsb ? v[0] : v[7];
   endfunction

   // shift one received bit in, dropping the sent one
   function automatic logic [7:0] shift_in(input logic [7:0] v,
                                           input logic b, input logic lsb);
      shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [1:0] pin_sync; // {sck, si} after two flops
   logic sck_s; // synchronised clock pin
   logic si_s; // synchronised data pin
   tws_ctl_t ctl, next_ctl; // mode control fields
   tws_csel_t csel, next_csel; // clock select fields
   logic [7:0] txbuf, next_txbuf; // transmit buffer
   logic [N_EV-1:0] stat, next_stat; // sticky events
   logic [N_EV-1:0] ien, next_ien; // event enables
   logic ack, next_ack; // access phase answered
   logic [31:0] rdata, next_rdata; // registered read data
   logic err, next_err; // registered slave error
   tws_rsel_t rsel; // decoded register
   logic xfer; // access completes this edge
   logic wr, rd; // completing write / read
   logic [N_EV-1:0] ev; // event pulses
   logic [N_EV-1:0] clr; // clear mask from software
   logic start_tx, start_rx; // transfer start requests
   logic core_rst_n; // reset of the shift engine
   tws_state_t state, next_state; // engine state
   logic [7:0] shreg, next_shreg; // serial_shift_register
   logic [2:0] bitcnt, next_bitcnt; // bits done
   logic so_reg, next_so_reg; // output line flop
   logic cap, next_cap; // bit captured on leading edge
   logic sck_gen, next_sck_gen; // generated serial clock
   logic [7:0] divcnt, next_divcnt; // half period counter
   logic sck_prev, next_sck_prev; // last sampled clock pin
   logic done; // eighth bit finished
   logic ext; // clock comes from the pin
   logic idle_lvl; // serial clock idle level
   logic tick; // generated clock toggles
   logic lead, trail; // serial clock edges
   logic [7:0] half; // half period for this source
   logic [7:0] nsh; // shifter after one bit

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   tws_sync #(.W(2)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .ce(ce),
      .d({sck_in, si}),
      .q(pin_sync)
   );
   assign sck_s = pin_sync[1];
   assign si_s = pin_sync[0];

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign xfer = psel && penable && ack && ce;
   assign wr = xfer && pwrite;
   assign rd = xfer && !pwrite;

   // word index to register select
   always_comb begin
      if (paddr[ADDR_W-1:IDX_LSB] == IDX_MODE_CTL) begin
         rsel = TWS_R_CTL;
      end else if (paddr[ADDR_W-1:IDX_LSB] == IDX_CLK_SEL) begin
         rsel = TWS_R_CSEL;
      end else if (paddr[ADDR_W-1:IDX_LSB] == IDX_TX_BUF) begin
         rsel = TWS_R_TXB;
      end else if (paddr[ADDR_W-1:IDX_LSB] == IDX_SHIFT) begin
         rsel = TWS_R_SHIFT;
      end else if (paddr[ADDR_W-1:IDX_LSB] == IDX_IRQ_STAT) begin
         rsel = TWS_R_STAT;
      end else if (paddr[ADDR_W-1:IDX_LSB] == IDX_IRQ_CLR) begin
         rsel = TWS_R_CLR;
      end else if (paddr[ADDR_W-1:IDX_LSB] == IDX_IRQ_EN) begin
         rsel = TWS_R_EN;
      end else begin
         rsel = TWS_R_NONE;
      end
   end

   // transfer starts; only taken while the engine is idle
   assign start_tx = wr && rsel == TWS_R_TXB && ctl.enable && ctl.tmode
                     && state == TWS_IDLE;
   assign start_rx = rd && rsel == TWS_R_SHIFT && ctl.enable && !ctl.tmode
                     && state == TWS_IDLE;

   // ----------------------------------------------------------------
   // register file next values
   // ----------------------------------------------------------------
   always_comb begin
      next_ctl = ctl;
      next_csel = csel;
      next_txbuf = txbuf;
      next_ien = ien;
      next_ack = psel && penable && !ack; // one wait state
      next_rdata = rdata;
      next_err = err;
      clr = '0;
      // buffer or shifter touched while a transfer runs
      ev = '0;
      ev[EV_DONE] = done;
      ev[EV_CLASH] = xfer && state == TWS_RUN
                     && (rsel == TWS_R_TXB || rsel == TWS_R_SHIFT);
      if (psel && penable && !ack) begin
         // answer prepared during the first access cycle
         next_err = (rsel == TWS_R_NONE);
         next_rdata = '0;
         if (rsel == TWS_R_CTL) begin
            next_rdata[POS_ENABLE] = ctl.enable;
            next_rdata[POS_TMODE] = ctl.tmode;
            next_rdata[POS_ORDER] = ctl.lsb_first;
            next_rdata[POS_ACTIVE] = (state == TWS_RUN);
         end else if (rsel == TWS_R_CSEL) begin
            next_rdata[POS_CKP] = csel.ckp;
            next_rdata[POS_DAP] = csel.dap;
            next_rdata[POS_SRC_HI:POS_SRC_LO] = csel.src;
         end else if (rsel == TWS_R_TXB) begin
            next_rdata[7:0] = txbuf;
         end else if (rsel == TWS_R_SHIFT) begin
            next_rdata[7:0] = shreg;
         end else if (rsel == TWS_R_STAT) begin
            next_rdata[N_EV-1:0] = stat;
         end else if (rsel == TWS_R_EN) begin
            next_rdata[N_EV-1:0] = ien;
         end
      end
      if (wr) begin
         if (rsel == TWS_R_CTL) begin
            // only bits 7, 6 and 4 written; bit 5, bits 3 to 1 and active flag ignored
            next_ctl.enable = pwdata[POS_ENABLE];
            next_ctl.tmode = pwdata[POS_TMODE];
            next_ctl.lsb_first = pwdata[POS_ORDER];
         end else if (rsel == TWS_R_CSEL) begin
            next_csel.ckp = pwdata[POS_CKP];
            next_csel.dap = pwdata[POS_DAP];
            next_csel.src = pwdata[POS_SRC_HI:POS_SRC_LO];
         end else if (rsel == TWS_R_TXB) begin
            next_txbuf = pwdata[7:0];
         end else if (rsel == TWS_R_CLR) begin
            clr = pwdata[N_EV-1:0];
         end else if (rsel == TWS_R_EN) begin
            next_ien = pwdata[N_EV-1:0];
         end
      end
      // a new event wins over a clear in the same cycle
      next_stat = (stat & ~clr) | ev;
   end

   // register file flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl <= tws_ctl_t'(RST_BYTE[2:0]);
         csel <= tws_csel_t'(RST_BYTE[4:0]);
         txbuf <= RST_BYTE;
         stat <= RST_EV;
         ien <= RST_EV;
         ack <= 1'b0;
         rdata <= 32'h0000_0000;
         err <= 1'b0;
      end else if (ce) begin
         ctl <= next_ctl;
         csel <= next_csel;
         txbuf <= next_txbuf;
         stat <= next_stat;
         ien <= next_ien;
         ack <= next_ack;
         rdata <= next_rdata;
         err <= next_err;
      end
   end

   assign pready = ack && ce;
   assign prdata = rdata;
   assign pslverr = err && ack;
   assign irq = |(stat & ien);

   // ----------------------------------------------------------------
   // serial clock edges
   // ----------------------------------------------------------------
   // clearing enable resets the engine straight away
   assign core_rst_n = presetn && ctl.enable;
   assign ext = (csel.src == SRC_EXT);
   assign idle_lvl = ~csel.ckp;
   assign half = HALF_BASE << csel.src;
   assign tick = !ext && state == TWS_RUN && divcnt == half - 8'h01;

   // leading leaves the idle level, trailing returns to it
   always_comb begin
      if (state != TWS_RUN) begin
         lead = 1'b0;
         trail = 1'b0;
      end else if (ext) begin
         lead = sck_s != sck_prev && sck_s != idle_lvl;
         trail = sck_s != sck_prev && sck_s == idle_lvl;
      end else begin
         lead = tick && sck_gen == idle_lvl;
         trail = tick && sck_gen != idle_lvl;
      end
   end

   // ----------------------------------------------------------------
   // shift engine next values
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_bitcnt = bitcnt;
      next_so_reg = so_reg;
      next_cap = cap;
      next_sck_prev = sck_s;
      next_sck_gen = sck_gen;
      next_divcnt = divcnt;
      done = 1'b0;
      nsh = shift_in(shreg, csel.dap ? si_s : cap, ctl.lsb_first);
      case (state)
         TWS_IDLE: begin
            next_sck_gen = idle_lvl;
            next_divcnt = '0;
            if (!ctl.tmode) begin
               next_so_reg = 1'b0;
            end
            if (start_tx) begin
               // buffer word goes to the shifter
               next_shreg = pwdata[7:0];
               next_bitcnt = '0;
               next_state = TWS_RUN;
               if (!csel.dap) begin
                  next_so_reg = out_bit(pwdata[7:0], ctl.lsb_first);
               end
            end else if (start_rx) begin
               next_bitcnt = '0;
               next_state = TWS_RUN;
            end
         end
         TWS_RUN: begin
            if (tick) begin
               next_divcnt = '0;
               next_sck_gen = ~sck_gen;
            end else if (!ext) begin
               next_divcnt = divcnt + 8'h01;
            end
            if (lead) begin
               if (!csel.dap) begin
                  next_cap = si_s;
               end else if (ctl.tmode) begin
                  next_so_reg = out_bit(shreg, ctl.lsb_first);
               end
            end
            if (trail) begin
               // send and receive in the same edge pair
               next_shreg = nsh;
               next_bitcnt = bitcnt + 3'h1;
               if (!csel.dap && ctl.tmode) begin
                  next_so_reg = out_bit(nsh, ctl.lsb_first);
               end
               if (bitcnt == BIT_LAST) begin
                  next_state = TWS_IDLE;
                  done = 1'b1;
               end
            end
         end
         default: begin
            next_state = TWS_IDLE;
         end
      endcase
   end

   // engine flops, cleared also while the unit is disabled
   always_ff @(posedge pclk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         state <= TWS_IDLE;
         shreg <= RST_BYTE;
         bitcnt <= '0;
         so_reg <= 1'b0;
         cap <= 1'b0;
         sck_gen <= 1'b1;
         divcnt <= '0;
         sck_prev <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         shreg <= next_shreg;
         bitcnt <= next_bitcnt;
         so_reg <= next_so_reg;
         cap <= next_cap;
         sck_gen <= next_sck_gen;
         divcnt <= next_divcnt;
         sck_prev <= next_sck_prev;
      end
   end

   // ----------------------------------------------------------------
   // pins: released to port use while the unit is disabled
   // ----------------------------------------------------------------
   assign so = so_reg;
   assign so_oe = ctl.enable;
   assign sck_out = sck_gen;
   assign sck_oe = ctl.enable && !ext;

endmodule

/* File: tb/tws_monitor.sv */
// checker of the serial unit's port behaviour, bound to the top module.
// assumes APB traffic at the ports is the only way registers change.
`timescale 1ns/10ps
module tws_monitor
   import tws_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sck_in,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe,
   input wire logic irq
);
   // ---------------------------------------------------------------
   // shadow of the registers, rebuilt from completed writes
   // ---------------------------------------------------------------
   logic [15:0] idx; // word index of the access
   logic wr_ok; // write completes this cycle
   logic rd_ok; // read completes this cycle
   logic start; // transfer launched this cycle
   logic mapped; // index inside the register map
   logic [7:0] ctl, next_ctl; // mode and control
   logic [7:0] csel, next_csel; // clock selection
   logic [1:0] ie, next_ie; // event enables
   logic [7:0] txb, next_txb; // transmit buffer
   logic [4:0] tog, next_tog; // clock toggles since the start
   logic sck_q; // clock level one cycle ago
   assign idx = paddr[17:2];
   assign wr_ok = psel && penable && pready && pwrite;
   assign rd_ok = psel && penable && pready && !pwrite;
   assign mapped = idx >= IDX_MODE_CTL && idx <= IDX_IRQ_EN;
   assign start = ctl[7] && ((wr_ok && idx == IDX_TX_BUF && ctl[6]) ||
                  (rd_ok && idx == IDX_SHIFT && !ctl[6]));
   // next shadow values; the counter restarts with every launch
   always_comb begin
      next_ctl = ctl;
      next_csel = csel;
      next_ie = ie;
      next_txb = txb;
      next_tog = tog;
      if (wr_ok && idx == IDX_MODE_CTL) next_ctl = pwdata[7:0] & 8'hD0;
      if (wr_ok && idx == IDX_CLK_SEL) next_csel = pwdata[7:0] & 8'h1F;
      if (wr_ok && idx == IDX_IRQ_EN) next_ie = pwdata[1:0];
      if (wr_ok && idx == IDX_TX_BUF) next_txb = pwdata[7:0];
      if (start || !ctl[7]) next_tog = 5'h00;
      else if (sck_out != sck_q && tog != 5'h1F) next_tog = tog + 5'h01;
   end
   // register the shadows
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl <= 8'h00;
         csel <= 8'h00;
         ie <= 2'h0;
         txb <= 8'h00;
         tog <= 5'h00;
         sck_q <= 1'b1;
      end else begin
         ctl <= next_ctl;
         csel <= next_csel;
         ie <= next_ie;
         txb <= next_txb;
         tog <= next_tog;
         sck_q <= sck_out;
      end
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_wait;
      (psel && !penable) ##1 (psel && penable && ce) |->
         !pready ##1 (pready || !ce);
   endproperty
   a_wait: assert property (p_wait) else $error("apb wait state wrong");
   property p_err;
      pready |-> pslverr == !mapped;
   endproperty
   a_err: assert property (p_err) else $error("slave error wrong");
   property p_ctl_rd;
      rd_ok && idx == IDX_MODE_CTL |-> prdata[31:1] == {24'h0, ctl[7:1]};
   endproperty
   a_ctl_rd: assert property (p_ctl_rd) else $error("ctl read");
   property p_txb_rd;
      rd_ok && idx == IDX_TX_BUF |-> prdata == {24'h0, txb};
   endproperty
   a_txb_rd: assert property (p_txb_rd) else $error("buffer read");
   property p_so_low;
      !ctl[6] && !$past(ctl[6]) |-> !so;
   endproperty
   a_so_low: assert property (p_so_low) else $error("so not low");
   property p_start_sck;
      start && csel[2:0] != SRC_EXT |-> ##[1:300] sck_out == csel[POS_CKP];
   endproperty
   a_start_sck: assert property (p_start_sck) else $error("no clock");
   property p_tog_max;
      tog <= 5'h10;
   endproperty
   a_tog_max: assert property (p_tog_max) else $error("too many");
   property p_done_irq;
      $changed(tog) && tog == 5'h10 && ie[0] |-> ##[0:3] irq;
   endproperty
   a_done_irq: assert property (p_done_irq) else $error("no done");
   property p_disable;
      $fell(ctl[7]) |-> ##[0:2] (!so && sck_out);
   endproperty
   a_disable: assert property (p_disable) else $error("no stop");
   c_tx: cover property (start && ctl[6]);
   c_rx: cover property (start && !ctl[6]);
   c_err: cover property (pready && pslverr);
   c_off: cover property ($fell(ctl[7]));
endmodule
bind tws_serial_io tws_monitor mon (
   .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .sck_in, .sck_out, .sck_oe, .si, .so,
   .so_oe, .irq
);

/* File: tb/tws_partner.sv */
// far-side peripheral: answers on si, captures so, can drive sck_in.
// assumes polarity 0, phase 0, and clr pulsed before every frame.
`timescale 1ns/10ps
module tws_partner (
   input wire logic clr,
   input wire logic ext,
   input wire logic go,
   input wire logic lsb,
   input wire logic sck_out,
   input wire logic so,
   input wire logic [7:0] tx_word,
   output logic sck_in,
   output logic si,
   output logic [7:0] rx_word
);
   logic sck; // clock the frame runs on
   logic [3:0] cnt; // bits handed over so far
   logic [2:0] pos; // bit of tx_word on the line
   assign sck = ext ? sck_in : sck_out;
   assign pos = lsb ? cnt[2:0] : 3'h7 - cnt[2:0];
   // past the eighth bit the line shows the inverse of the last bit
   assign si = cnt[3] ? ~tx_word[lsb ? 3'h7 : 3'h0] : tx_word[pos];
   // capture so on the leading (falling) edge
   always @(negedge sck or posedge clr) begin
      if (clr) rx_word <= 8'h00;
      else if (lsb) rx_word <= {so, rx_word[7:1]};
      else rx_word <= {rx_word[6:0], so};
   end
   // next bit after each trailing edge
   always @(posedge sck or posedge clr) begin
      if (clr) cnt <= 4'h0;
      else if (!cnt[3]) cnt <= cnt + 4'h1;
   end
   // master clock: eight periods of 400 ns, then it stands high
   initial sck_in = 1'b1;
   always @(posedge go) begin
      #37;
      repeat (8) begin
         sck_in = 1'b0;
         #200;
         sck_in = 1'b1;
         #200;
      end
   end
endmodule

/* File: tb/testbench.sv */
// self-checking bench of the serial unit: APB master, peripheral model.
// assumes the checker is bound in; ce drops once, in mid-frame.
`timescale 1ns/10ps
module testbench
   import tws_pkg::*;
;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic sck_in, sck_out, sck_oe, si, so, so_oe, irq;
   logic clr, ext, go, lsb; // peripheral controls
   logic [7:0] ptx, prx; // peripheral words
   int error_cnt, tests_run;
   tws_serial_io dut (
      .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sck_in, .sck_out, .sck_oe, .si, .so,
      .so_oe, .irq
   );
   tws_partner peer (
      .clr, .ext, .go, .lsb, .sck_out, .so, .tx_word(ptx), .sck_in, .si,
      .rx_word(prx)
   );
   // 20 MHz clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic end_of_test;
      $display("mismatches %0d of %0d checks", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // one APB transfer; data is taken at the edge that sees pready
   task automatic apb(input logic [15:0] ix, input logic w,
                      input logic [7:0] wd, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {ix, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         $display("BAD %0t no ready", $time);
         end_of_test();
      end
   endtask
   task automatic wr(input logic [15:0] ix, input logic [7:0] d);
      logic [31:0] rd;
      logic er;
      apb(ix, 1'b1, d, rd, er);
   endtask
   task automatic rdc(input logic [15:0] ix, input logic [31:0] e);
      logic [31:0] rd;
      logic er;
      apb(ix, 1'b0, 8'h00, rd, er);
      chk(rd, e);
      chk(er, 1'b0);
   endtask
   task automatic irqchk(input logic e);
      @(negedge pclk);
      chk(irq, e);
   endtask
   // poll the active flag, touching nothing else meanwhile
   task automatic wait_done;
      logic [31:0] rd;
      logic er;
      int n;
      n = 0;
      do begin
         apb(IDX_MODE_CTL, 1'b0, 8'h00, rd, er);
         n++;
      end while (rd[0] !== 1'b0 && n < 100);
      if (n >= 100) begin
         error_cnt++;
         $display("BAD %0t transfer hangs", $time);
         end_of_test();
      end
      @(negedge pclk);
   endtask
   // one frame: d goes out (md=1), the peripheral answers b
   task automatic xfer(input logic md, input logic l, input logic [7:0] d,
                       input logic [7:0] b, input logic ex, input logic ie);
      logic [31:0] rd;
      logic er;
      lsb <= l;
      ptx <= b;
      ext <= ex;
      clr <= 1'b1;
      wr(IDX_MODE_CTL, {1'b1, md, 1'b0, l, 4'h0});
      clr <= 1'b0;
      apb(md ? IDX_TX_BUF : IDX_SHIFT, md, d, rd, er);
      chk({so_oe, sck_oe}, {1'b1, !ex});
      if (ex) go <= 1'b1;
      apb(IDX_MODE_CTL, 1'b0, 8'h00, rd, er);
      chk(rd[0], 1'b1);
      wait_done();
      go <= 1'b0;
      chk(irq, ie);
      rdc(IDX_IRQ_STAT, 8'h01);
      chk(prx, md ? d : 8'h00);
      rdc(IDX_SHIFT, b);
      if (!md) wait_done();
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] rd;
      logic er;
      logic [7:0] d, b;
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h00000000;
      {clr, ext, go, lsb, ptx} = {4'hC, 8'h00};
      error_cnt = 0;
      tests_run = 0;
      void'($urandom(32'h9f1b7335));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({so_oe, sck_oe}, 2'b00);
      for (int i = 0; i < 7; i++) begin
         rdc(IDX_MODE_CTL + 16'(i), 8'h00);
      end
      apb(16'hFF87, 1'b0, 8'h00, rd, er);
      chk(er, 1'b1);
      chk(rd, 32'h00000000);
      wr(IDX_CLK_SEL, 8'hFF);
      rdc(IDX_CLK_SEL, 8'h1F);
      wr(IDX_MODE_CTL, 8'hFF);
      rdc(IDX_MODE_CTL, 8'hD0);
      wr(IDX_CLK_SEL, 8'h01);
      // corners first, then random words; 4 receives, 7 on sck_in
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : 8'($urandom);
         b = 8'($urandom);
         wr(IDX_IRQ_EN, (i == 1) ? 8'h02 : 8'h03);
         if (i == 7) wr(IDX_CLK_SEL, 8'h07);
         xfer(i != 4, i[0], d, b, i == 7, i != 1);
         if (i == 1) begin
            wr(IDX_IRQ_EN, 8'h03);
            irqchk(1'b1);
         end
         wr(IDX_IRQ_CLR, 8'h01);
         irqchk(1'b0);
      end
      // disable in mid-frame, mode kept
      wr(IDX_CLK_SEL, 8'h01);
      clr <= 1'b1;
      wr(IDX_MODE_CTL, 8'hC0);
      wr(IDX_TX_BUF, 8'hA5);
      // frozen clock enable stretches the frame past its length
      ce <= 1'b0;
      repeat (80) @(posedge pclk);
      ce <= 1'b1;
      rdc(IDX_MODE_CTL, 8'hC1);
      repeat (10) @(posedge pclk);
      wr(IDX_MODE_CTL, 8'h40);
      rdc(IDX_SHIFT, 8'h00);
      rdc(IDX_MODE_CTL, 8'h40);
      // buffer write in receive mode stores only
      wr(IDX_MODE_CTL, 8'h80);
      wr(IDX_TX_BUF, 8'h3C);
      rdc(IDX_MODE_CTL, 8'h80);
      rdc(IDX_TX_BUF, 8'h3C);
      end_of_test();
   end
endmodule
